// file: fsprb_status.sv
// Fault flag register, driver gating and pin readback for the gate driver
`timescale 1ns/1ps
`default_nettype none
`include "fsprb_cfg.svh"
module fsprb_status
    import fsprb_pkg::*;
(
    input  wire logic         clock,                    // 250 MHz system clock
    input  wire logic         sys_rst,                  // Synchronous, active high
    // Register access from the serial port decoder (same clock)
    input  wire fsprb_addr_t  reg_addr,                 // Register address
    input  wire logic         reg_wr,                   // Write strobe, one cycle
    input  wire fsprb_word_t  reg_wdata,                // Write data
    input  wire logic         reg_rd,                   // Read strobe, one cycle
    output var  fsprb_word_t  reg_rdata,                // Read data, one cycle later
    // Gate control and enable pins (asynchronous)
    input  wire logic         phase_u_low_gate_input,
    input  wire logic         phase_u_high_gate_input,
    input  wire logic         phase_v_low_gate_input,
    input  wire logic         phase_v_high_gate_input,
    input  wire logic         phase_w_low_gate_input,
    input  wire logic         phase_w_high_gate_input,
    input  wire logic         drv_en_pin,               // Driver enable pin
    // Temperature comparators (asynchronous levels)
    input  wire logic         temp_prewarn,             // Prewarning comparator
    input  wire logic         temp_threshold_low,
    input  wire logic         temp_threshold_mid,
    input  wire logic         temp_shutdown,            // Overtemperature level
    // Analog fault detectors (asynchronous levels)
    input  wire logic         pump_undervoltage,
    input  wire fsprb_phase_t short_count_hit,          // Short counter triggered
    input  wire fsprb_phase_t ground_short_detect,
    input  wire fsprb_phase_t supply_short_detect,
    // Outputs
    output var  logic         status_out,               // Status pin
    output var  logic         gate_driver_enable        // Driver may switch
);
    // ------------------------------------------------------------------
    // Input synchronisation
    // ------------------------------------------------------------------
    localparam int SYNC_W = 21;
    logic [SYNC_W-1:0] raw_in;    // Asynchronous bundle
    logic [SYNC_W-1:0] sync_in;   // Synchronised bundle
    logic [5:0]        gate_s;    // Gate inputs, UL first
    logic              drv_en_s;  // Enable pin
    logic [2:0]        temp_s;    // Prewarn, low, mid comparators
    logic              ot_s;      // Overtemperature
    logic              uv_s;      // Pump undervoltage
    fsprb_phase_t      sc_s;      // Short counter hits
    fsprb_phase_t      gnd_s;     // Ground shorts
    fsprb_phase_t      sup_s;     // Supply shorts

    assign raw_in = {supply_short_detect, ground_short_detect, short_count_hit,
                     pump_undervoltage, temp_shutdown,
                     temp_threshold_mid, temp_threshold_low, temp_prewarn,
                     drv_en_pin,
                     phase_w_high_gate_input, phase_w_low_gate_input,
                     phase_v_high_gate_input, phase_v_low_gate_input,
                     phase_u_high_gate_input, phase_u_low_gate_input};

    fsprb_sync #(
        .WIDTH (SYNC_W)
    ) u_sync (
        .clock    (clock),
        .sys_rst  (sys_rst),
        .async_in (raw_in),
        .sync_out (sync_in)
    );

    assign gate_s   = sync_in[5:0];
    assign drv_en_s = sync_in[6];
    assign temp_s   = sync_in[9:7];
    assign ot_s     = sync_in[10];
    assign uv_s     = sync_in[11];
    assign sc_s     = sync_in[14:12];
    assign gnd_s    = sync_in[17:15];
    assign sup_s    = sync_in[20:18];

    // ------------------------------------------------------------------
    // Enable pin edge detection
    // ------------------------------------------------------------------
    logic drv_en_q;       // Enable pin one cycle ago
    logic next_drv_en_q;
    logic drv_toggle;     // Either edge of the enable pin

    // Both edges count, so a full off/on cycle clears twice harmlessly
    always_comb begin
        next_drv_en_q = drv_en_s;
        drv_toggle    = drv_en_s ^ drv_en_q;
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            drv_en_q <= 1'b0;
        end else begin
            drv_en_q <= next_drv_en_q;
        end
    end

    // ------------------------------------------------------------------
    // Fault flags
    // ------------------------------------------------------------------
    fsprb_flags_t flags;        // Latched fault flags
    fsprb_flags_t next_flags;
    fsprb_flags_t set_vec;      // Events raising flags this cycle
    fsprb_flags_t clr_vec;      // Clears requested this cycle
    logic         fault_wr;     // Write to the flag register

    assign fault_wr = reg_wr && (reg_addr == `FSPRB_ADDR_FAULT);

    // Set terms gathered per phase in one loop
    always_comb begin
        set_vec                      = '0;
        set_vec[`FSPRB_BIT_OTPW]     = temp_s[0];
        set_vec[`FSPRB_BIT_OT]       = ot_s;
        set_vec[`FSPRB_BIT_PUMP_UV]  = uv_s;
        for (int p = 0; p < 3; p++) begin
            set_vec[`FSPRB_BIT_SC_BASE  + p*`FSPRB_PHASE_STRIDE] = sc_s[p];
            set_vec[`FSPRB_BIT_GND_BASE + p*`FSPRB_PHASE_STRIDE] = gnd_s[p];
            set_vec[`FSPRB_BIT_SUP_BASE + p*`FSPRB_PHASE_STRIDE] = sup_s[p];
        end
    end

    // Write-one clears plus enable toggle; reset flag needs enable high
    always_comb begin
        clr_vec = '0;
        if (fault_wr) begin
            clr_vec = reg_wdata[14:0] & `FSPRB_MASK_IMPL;
            if (!drv_en_s) begin
                clr_vec[`FSPRB_BIT_RESET] = 1'b0;
            end
        end
        if (drv_toggle) begin
            clr_vec = clr_vec | `FSPRB_MASK_TOGGLE_CLR;
        end
    end

    // A set in the same cycle as its clear wins, so no event is lost;
    // level-driven flags therefore stay up while their condition lasts
    always_comb begin
        next_flags = ((flags & ~clr_vec) | set_vec) & `FSPRB_MASK_IMPL;
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            flags <= `FSPRB_FLAGS_RESET;
        end else begin
            flags <= next_flags;
        end
    end

    // ------------------------------------------------------------------
    // Driver gating and status pin
    // ------------------------------------------------------------------
    logic next_status;
    logic next_enable;

    // Built from next_flags so the pins line up with the flag register
    always_comb begin
        next_status = |(next_flags & `FSPRB_MASK_STATUS);
        next_enable = drv_en_s && !uv_s
                      && !(|(next_flags & `FSPRB_MASK_SHORTS))
                      && !next_flags[`FSPRB_BIT_OT];
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            status_out         <= 1'b0;
            gate_driver_enable <= 1'b0;
        end else begin
            status_out         <= next_status;
            gate_driver_enable <= next_enable;
        end
    end

    // ------------------------------------------------------------------
    // Register read
    // ------------------------------------------------------------------
    fsprb_word_t next_rdata;

    // Unmapped addresses and idle cycles return zero
    always_comb begin
        next_rdata = '0;
        if (reg_rd) begin
            case (reg_addr)
                `FSPRB_ADDR_FAULT: begin
                    next_rdata[14:0] = flags;
                end
                `FSPRB_ADDR_PINS: begin
                    next_rdata[`FSPRB_PIN_GATE_LSB +: 6] = gate_s;
                    next_rdata[`FSPRB_PIN_DRV_EN]       = drv_en_s;
                    next_rdata[`FSPRB_PIN_TEMP_LSB +: 3] = temp_s;
                end
                default: begin
                    next_rdata = '0;
                end
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            reg_rdata <= '0;
        end else begin
            reg_rdata <= next_rdata;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    sequence s_toggle;
        drv_toggle;
    endsequence

    sequence s_no_raise;
        set_vec == '0;
    endsequence

    uv_set_a: assert property (uv_s |=> flags[`FSPRB_BIT_PUMP_UV])
        else $error("undervoltage did not set its flag");
    uv_off_a: assert property (uv_s |=> !gate_driver_enable)
        else $error("driver enabled during undervoltage");
    uv_hold_a: assert property (flags[`FSPRB_BIT_PUMP_UV] && !clr_vec[`FSPRB_BIT_PUMP_UV]
        |=> flags[`FSPRB_BIT_PUMP_UV])
        else $error("undervoltage flag dropped without a clear");
    for (genvar p = 0; p < 3; p++) begin : g_phase_chk
        sc_set_a: assert property (sc_s[p] |=> flags[4 + 4*p])
            else $error("short counter flag not set");
        gnd_set_a: assert property (gnd_s[p] |=> flags[5 + 4*p])
            else $error("ground short flag not set");
        sup_set_a: assert property (sup_s[p] |=> flags[6 + 4*p])
            else $error("supply short flag not set");
    end
    short_off_a: assert property (|(flags & `FSPRB_MASK_SHORTS) |-> !gate_driver_enable)
        else $error("driver enabled with a short flag set");
    status_or_a: assert property (##1 status_out == |(flags & `FSPRB_MASK_STATUS))
        else $error("status pin disagrees with flags");
    w1c_clear_a: assert property (fault_wr && reg_wdata[4] && !sc_s[0]
        |=> !flags[4])
        else $error("write one did not clear the flag");
    toggle_clear_a: assert property (s_toggle ##0 s_no_raise
        |=> (flags & `FSPRB_MASK_TOGGLE_CLR) == '0 && flags[0] == $past(flags[0]))
        else $error("enable toggle clear wrong");
    pin_read_a: assert property (reg_rd && reg_addr == `FSPRB_ADDR_PINS
        |=> reg_rdata == {21'h000000, $past(temp_s), 1'b0, $past(drv_en_s), $past(gate_s)})
        else $error("pin readback mismatch");
    unused_zero_a: assert property (##1 !flags[7] && !flags[11])
        else $error("unused flag bit set");
endmodule
`default_nettype wire

// file: fsprb_cfg.svh
// Constants for the fault status and pin readback block
`ifndef FSPRB_CFG_SVH
`define FSPRB_CFG_SVH

// ----------------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------------
`define FSPRB_ADDR_FAULT      7'h01
`define FSPRB_ADDR_PINS       7'h04

// ----------------------------------------------------------------------
// Fault flag positions
// ----------------------------------------------------------------------
`define FSPRB_BIT_RESET       0
`define FSPRB_BIT_OTPW        1
`define FSPRB_BIT_OT          2
`define FSPRB_BIT_PUMP_UV     3
`define FSPRB_BIT_SC_BASE     4
`define FSPRB_BIT_GND_BASE    5
`define FSPRB_BIT_SUP_BASE    6
`define FSPRB_PHASE_STRIDE    4

// ----------------------------------------------------------------------
// Fault flag masks and reset value
// ----------------------------------------------------------------------
`define FSPRB_FLAGS_RESET     15'h0001
`define FSPRB_MASK_IMPL       15'h777F
`define FSPRB_MASK_STATUS     15'h777C
`define FSPRB_MASK_TOGGLE_CLR 15'h777C
`define FSPRB_MASK_SHORTS     15'h6660

// ----------------------------------------------------------------------
// Pin readback layout
// ----------------------------------------------------------------------
`define FSPRB_PIN_GATE_LSB    0
`define FSPRB_PIN_DRV_EN      6
`define FSPRB_PIN_TEMP_LSB    8

`endif

// file: fsprb_pkg.sv
// Types shared by the fault status and pin readback block
package fsprb_pkg;
    typedef logic [14:0] fsprb_flags_t;   // Fault flag word
    typedef logic [6:0]  fsprb_addr_t;    // Register address
    typedef logic [31:0] fsprb_word_t;    // Register data word
    typedef logic [2:0]  fsprb_phase_t;   // One bit per phase U, V, W
endpackage

// file: fsprb_sync.sv
// Two-stage synchroniser for asynchronous pin and detector levels
`timescale 1ns/1ps
`default_nettype none
module fsprb_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clock,
    input  wire logic             sys_rst,
    input  wire logic [WIDTH-1:0] async_in,
    output var  logic [WIDTH-1:0] sync_out
);
    // ------------------------------------------------------------------
    // Per-bit flop pair
    // ------------------------------------------------------------------
    // The first stage feeds only the second; nothing else may look at it
    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
        logic meta;       // First stage, may go metastable
        logic next_meta;  // Next first stage
        logic next_out;   // Next second stage
        always_comb begin
            next_meta = async_in[i];
            next_out  = meta;
        end
        always_ff @(posedge clock) begin
            if (sys_rst) begin
                meta        <= 1'b0;
                sync_out[i] <= 1'b0;
            end else begin
                meta        <= next_meta;
                sync_out[i] <= next_out;
            end
        end
    end
endmodule
`default_nettype wire

// file: fsprb_host.sv
// Host controller model driving the register strobe port
`timescale 1ns/1ps
`default_nettype none
module fsprb_host
    import fsprb_pkg::*;
(
    input  wire logic        clock,     // Shared system clock
    output var  fsprb_addr_t reg_addr,  // Register address
    output var  logic        reg_wr,    // Write strobe
    output var  fsprb_word_t reg_wdata, // Write data
    output var  logic        reg_rd,    // Read strobe
    input  wire fsprb_word_t reg_rdata  // Read data
);
    // --------------------------------------------------------------
    // Idle bus at time zero
    // --------------------------------------------------------------
    initial begin
        reg_addr  = '0;
        reg_wr    = 1'b0;
        reg_wdata = '0;
        reg_rd    = 1'b0;
    end
    // One-cycle write; clearing uses ones in the flag positions
    task automatic wr_reg(input fsprb_addr_t a, input fsprb_word_t d);
        @(posedge clock);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clock);
        reg_wr    <= 1'b0;
    endtask
    // Read data is taken in the single cycle it stands
    task automatic rd_reg(input fsprb_addr_t a, output fsprb_word_t d);
        @(posedge clock);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clock);
        reg_rd   <= 1'b0;
        #1 d = reg_rdata;
    endtask
endmodule
`default_nettype wire

// file: tb_fault_status_and_pin_readback.sv
// Self-checking bench for the fault status and pin readback block
`timescale 1ns/1ps
`default_nettype none
`include "fsprb_cfg.svh"
module tb_fault_status_and_pin_readback;
    import fsprb_pkg::*;
    // --------------------------------------------------------------
    // Stimulus and observed signals
    // --------------------------------------------------------------
    logic        clock = 1'b0;   // 4 ns clock
    logic        sys_rst = 1'b1; // Held at start
    fsprb_addr_t reg_addr;       // From host model
    logic        reg_wr;         // From host model
    fsprb_word_t reg_wdata;      // From host model
    logic        reg_rd;         // From host model
    fsprb_word_t reg_rdata;      // Read data
    logic [5:0]  gates = '0;     // Gate inputs UL..WH
    logic        drv_en = 1'b0;  // Enable pin
    logic [2:0]  temps = '0;     // Prewarn, low, mid comparators
    logic        temp_sd = 1'b0; // Shutdown comparator
    logic [9:0]  src = '0;       // Uv, counters, ground, supply
    logic        status_out;     // Status pin
    logic        gate_en;        // Driver enable
    int          n_fail = 0;     // Mismatches
    int          num_checks = 0; // Comparisons
    logic [31:0] rng = 32'h5C977DF2; // Fixed seed
    fsprb_word_t rd;             // Last read value
    int          fbit[10] = '{3, 4, 8, 12, 5, 9, 13, 6, 10, 14}; // Flag per source

    always #2 clock = ~clock;

    fsprb_host i_host (.clock(clock), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

    fsprb_status i_dut (.clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .phase_u_low_gate_input(gates[0]), .phase_u_high_gate_input(gates[1]),
        .phase_v_low_gate_input(gates[2]), .phase_v_high_gate_input(gates[3]),
        .phase_w_low_gate_input(gates[4]), .phase_w_high_gate_input(gates[5]),
        .drv_en_pin(drv_en), .temp_prewarn(temps[0]), .temp_threshold_low(temps[1]),
        .temp_threshold_mid(temps[2]), .temp_shutdown(temp_sd),
        .pump_undervoltage(src[0]), .short_count_hit(src[3:1]),
        .ground_short_detect(src[6:4]), .supply_short_detect(src[9:7]),
        .status_out(status_out), .gate_driver_enable(gate_en));

    // --------------------------------------------------------------
    // Helpers
    // --------------------------------------------------------------
    function automatic logic [31:0] next_rand(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    // Pin readback layout; bit 7 is always zero
    function automatic fsprb_word_t exp_pins(input logic [5:0] g, input logic e,
                                              input logic [2:0] t);
        return {21'h000000, t, 1'b0, e, g};
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Three edges through synchroniser and flag stage, plus margin
    task automatic settle();
        repeat (4) @(posedge clock);
        #1;
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // Hang guard well above the sequence length
    initial begin
        repeat (20000) @(posedge clock);
        n_fail++;
        test_done();
    end

    // --------------------------------------------------------------
    // Main sequence
    // --------------------------------------------------------------
    initial begin
        repeat (2) @(posedge clock);
        sys_rst <= 1'b0;
        settle();
        check(status_out, 1'b0);
        check(gate_en, 1'b0);
        i_host.rd_reg(7'h01, rd);
        check(rd, 32'h00000001);
        // Enable high, then drop the reset indication
        @(posedge clock);
        drv_en <= 1'b1;
        settle();
        i_host.wr_reg(7'h01, 32'h00000001);
        settle();
        i_host.rd_reg(7'h01, rd);
        check(rd, 32'h00000000);
        check(gate_en, 1'b1);
        // Random live pin levels
        for (int i = 0; i < 8; i++) begin
            rng = next_rand(rng);
            @(posedge clock);
            gates <= rng[5:0];
            temps <= rng[10:8];
            settle();
            i_host.rd_reg(7'h04, rd);
            check(rd, exp_pins(rng[5:0], 1'b1, rng[10:8]));
        end
        @(posedge clock);
        temps <= '0;
        settle();
        i_host.wr_reg(7'h01, 32'h00007FFF);
        i_host.rd_reg(7'h02, rd);
        check(rd, 32'h00000000);
        // Each fault source in turn: set, latch, clear
        for (int k = 0; k < 10; k++) begin
            @(posedge clock);
            src <= 10'(1) << k;
            settle();
            // Short counter hits are information only and leave the driver on
            check(gate_en, (fbit[k] % 4 == 0) ? 1'b1 : 1'b0);
            check(status_out, 1'b1);
            @(posedge clock);
            src <= '0;
            settle();
            i_host.rd_reg(7'h01, rd);
            check(rd, 32'(1) << fbit[k]);
            check(status_out, 1'b1);
            check(gate_en, (fbit[k] % 4 == 1 || fbit[k] % 4 == 2) ? 1'b0 : 1'b1);
            i_host.wr_reg(7'h01, (32'(1) << fbit[k]) | 32'h00000880);
            #1;
            check(status_out, 1'b0);
            check(gate_en, 1'b1);
            i_host.rd_reg(7'h01, rd);
            check(rd, 32'h00000000);
        end
        // Overtemperature latches bit 2 and holds the driver off until cleared
        @(posedge clock);
        temp_sd <= 1'b1;
        settle();
        check(gate_en, 1'b0);
        check(status_out, 1'b1);
        @(posedge clock);
        temp_sd <= 1'b0;
        settle();
        i_host.rd_reg(7'h01, rd);
        check(rd, 32'h00000004);
        check(gate_en, 1'b0);
        i_host.wr_reg(7'h01, 32'h00000004);
        #1;
        check(status_out, 1'b0);
        check(gate_en, 1'b1);
        // Enable toggle clears shorts but keeps the prewarning flag
        @(posedge clock);
        src <= 10'h090;
        temps <= 3'b001;
        settle();
        @(posedge clock);
        src <= '0;
        temps <= '0;
        drv_en <= 1'b0;
        settle();
        i_host.rd_reg(7'h04, rd);
        check(rd, exp_pins(gates, 1'b0, 3'b000));
        @(posedge clock);
        drv_en <= 1'b1;
        settle();
        i_host.rd_reg(7'h01, rd);
        check(rd, 32'h00000002);
        check(gate_en, 1'b1);
        test_done();
    end
endmodule
`default_nettype wire
